// ==== core/sch_defines.svh ====
// Purpose: shared constants of the settings command handler
// Assumes: included by bare name, after the package where types are needed
// Notes:   every offset-free value, timing figure and reset value but the zero range limit (ZLIMIT_RST) lives here
`ifndef SCH_DEFINES_SVH
`define SCH_DEFINES_SVH

`define SCH_TIME_W      16
`define SCH_CMD_TIME_W  20
`define SCH_TIME_MAX    16'ha8c0
`define SCH_MODE_MAX    2'h1
`define SCH_RST_AUTO    1'h0
`define SCH_RST_TIME    16'h0000
`define SCH_RST_REMIND  1'h0
`define SCH_SEC_NS      1000000000
`define SCH_CLK_NS      40
`define SCH_SYNC_W      3

`endif

// ==== core/sch_pkg.sv ====
// Purpose: types of the settings command handler
// Assumes: nothing is imported, users write sch_pkg::name
// Notes:   enums carry no explicit codes
package sch_pkg;
   typedef enum logic [1:0] {
      auto_off_setting_cmd, zero_range_limit_cmd, service_reminder_cmd, power_down_cmd
   } sch_cmd_t;
   typedef enum logic [1:0] {
      rsp_ack, rsp_query_data, rsp_busy, rsp_param_error
   } sch_rsp_t;
   typedef enum logic [1:0] {pwr_run, pwr_standby, pwr_off} sch_pwr_t;
endpackage

// ==== core/sch_idle_if.sv ====
// Purpose: link between command handler and inactivity timer
// Assumes: one clock domain
// Notes:   expire is a one-cycle pulse from a flip-flop
`timescale 1ns/100ps
`include "sch_defines.svh"
interface sch_idle_if;
   logic                   restart;   // activity seen, count from zero
   logic                   enable;    // auto-off mode
   logic [`SCH_TIME_W-1:0] limit;     // programmed seconds
   logic                   expire;    // inactivity reached the limit
   modport ctrl  (output restart, enable, limit, input expire);
   modport timer (input restart, enable, limit, output expire);
endinterface

// ==== core/sch_idle_timer.sv ====
// Purpose: whole-second inactivity counter
// Assumes: restart comes from logic on the same clock
// Notes:   fires once per idle stretch, never with a zero limit
`timescale 1ns/100ps
`include "sch_defines.svh"
module sch_idle_timer #(
   parameter int CYC_PER_SEC = `SCH_SEC_NS / `SCH_CLK_NS
) (
   input wire logic i_core_clk,   // system clock
   input wire logic i_sys_rst,    // synchronous reset
   input wire logic i_clk_en,     // freezes all state when low
   sch_idle_if.timer idle         // control and expire pulse
);
   localparam int PW = $clog2(CYC_PER_SEC);

   generate
      if (CYC_PER_SEC < 2) begin : g_bad
         $error("CYC_PER_SEC must be at least 2");
      end
   endgenerate

   typedef struct packed {
      logic [PW-1:0]          presc;
      logic [`SCH_TIME_W-1:0] secs;
      logic                   fired;
      logic                   expire;
   } sch_tmr_state_t;

   sch_tmr_state_t st_ff;
   sch_tmr_state_t nxt_st;

   ////////////////////////////////////////////////////////////////////////
   // seconds prescaler and saturating count; fired blocks repeat pulses
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.expire = 1'b0;
      if (idle.restart) begin
         nxt_st.presc = '0;
         nxt_st.secs  = '0;
         nxt_st.fired = 1'b0;
      end else begin
         if (st_ff.presc == PW'(CYC_PER_SEC - 1)) begin
            nxt_st.presc = '0;
            if (st_ff.secs != '1) begin
               nxt_st.secs = st_ff.secs + 1'b1;
            end
         end else begin
            nxt_st.presc = st_ff.presc + 1'b1;
         end
         if (idle.enable && idle.limit != '0 && st_ff.secs >= idle.limit && !st_ff.fired) begin
            nxt_st.expire = 1'b1;
            nxt_st.fired  = 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_ff <= '0;
      end else if (i_clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign idle.expire = st_ff.expire;

   property p_tmr_no_zero;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      $rose(idle.expire) |-> $past(idle.enable) && $past(idle.limit) != '0;
   endproperty
   a_tmr_no_zero: assert property (p_tmr_no_zero) else $error("expire without limit");
endmodule // sch_idle_timer

// ==== core/sch_zero_tare.sv ====
// Purpose: decide zero or tare for the combined key
// Assumes: load and limit share one fixed-point definition unit
// Notes:   zero point is captured once at switch-on
`timescale 1ns/100ps
module sch_zero_tare #(
   parameter int LOAD_W = 24
) (
   input  wire logic                     i_core_clk,     // system clock
   input  wire logic                     i_sys_rst,      // synchronous reset
   input  wire logic                     i_clk_en,       // freezes state when low
   input  wire logic                     i_press,        // key press pulse
   input  wire logic                     i_zero_capture, // switch-on zero pulse
   input  wire logic signed [LOAD_W-1:0] i_load,         // current load
   input  wire logic signed [LOAD_W-1:0] i_limit,        // zero range limit
   output logic                          o_do_zero,      // zero pulse
   output logic                          o_do_tare       // tare pulse
);
   generate
      if (LOAD_W < 8) begin : g_bad
         $error("LOAD_W too small");
      end
   endgenerate

   typedef struct packed {
      logic signed [LOAD_W-1:0] zero_pt;
      logic                     do_zero;
      logic                     do_tare;
   } sch_zt_state_t;

   sch_zt_state_t            st_ff;
   sch_zt_state_t            nxt_st;
   logic signed [LOAD_W:0]   rel_load;
   logic                     in_range;

   // one extra bit keeps the difference from wrapping
   // concatenations are unsigned, so the sign is put back before compare
   assign rel_load = $signed({i_load[LOAD_W-1], i_load}) -
                     $signed({st_ff.zero_pt[LOAD_W-1], st_ff.zero_pt});
   assign in_range = rel_load <= $signed({i_limit[LOAD_W-1], i_limit});

   ////////////////////////////////////////////////////////////////////////
   // capture of the reference and the zero-or-tare choice
   always_comb begin
      nxt_st         = st_ff;
      nxt_st.do_zero = 1'b0;
      nxt_st.do_tare = 1'b0;
      if (i_zero_capture) begin
         nxt_st.zero_pt = i_load;
      end
      if (i_press) begin
         nxt_st.do_zero = in_range;
         nxt_st.do_tare = !in_range;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_ff <= '0;
      end else if (i_clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign o_do_zero = st_ff.do_zero;
   assign o_do_tare = st_ff.do_tare;

   property p_zt_pick;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_clk_en && i_press) |=> (o_do_zero == $past(in_range)) && (o_do_tare != o_do_zero);
   endproperty
   a_zt_pick: assert property (p_zt_pick) else $error("wrong zero or tare choice");
endmodule // sch_zero_tare

// ==== core/sch_settings_top.sv ====
// Purpose: auto-off, zero range and service reminder setting commands
// Assumes: commands arrive already parsed, one per reply
// Notes:   power-down state holds until reset
`timescale 1ns/100ps
`include "sch_defines.svh"
module sch_settings_top #(
   parameter int                 LOAD_W      = 24,
   parameter int                 CYC_PER_SEC = `SCH_SEC_NS / `SCH_CLK_NS,
   parameter logic [LOAD_W-1:0]  ZLIMIT_RST  = '0
) (
   input  wire logic                         i_core_clk,     // 25 MHz system clock
   input  wire logic                         i_sys_rst,      // synchronous reset
   input  wire logic                         i_clk_en,       // freezes all state when low
   input  wire logic                         i_cmd_valid,    // parsed command pulse
   input  wire sch_pkg::sch_cmd_t            i_cmd_code,     // which command
   input  wire logic                         i_cmd_query,    // bare query form
   input  wire logic [1:0]                   i_cmd_mode,     // mode parameter
   input  wire logic [`SCH_CMD_TIME_W-1:0]   i_cmd_time,     // time parameter, seconds
   input  wire logic signed [LOAD_W-1:0]     i_cmd_limit,    // zero range parameter
   input  wire logic                         i_exec_busy,    // cannot execute now
   input  wire logic                         i_nv_erase,     // settings store erased
   input  wire logic                         i_on_battery,   // pin: battery supply
   input  wire logic                         i_key_zt,       // pin: zero/tare key
   input  wire logic                         i_key_any,      // pin: any other key
   input  wire logic signed [LOAD_W-1:0]     i_load,         // current load
   input  wire logic                         i_zero_capture, // switch-on zero pulse
   input  wire logic                         i_service_due,  // service date reached
   input  wire logic                         i_hours_due,    // hours threshold reached
   output logic                              o_rsp_valid,    // reply pulse
   output sch_pkg::sch_rsp_t                 o_rsp_kind,     // reply outcome
   output logic                              o_rsp_mode,     // queried mode
   output logic [`SCH_TIME_W-1:0]            o_rsp_time,     // queried time
   output logic signed [LOAD_W-1:0]          o_rsp_limit,    // queried limit
   output logic                              o_standby,      // in standby
   output logic                              o_power_off,    // fully off
   output logic                              o_do_zero,      // zero pulse
   output logic                              o_do_tare,      // tare pulse
   output logic                              o_reminder_icon // show reminder icon
);
   typedef struct packed {
      logic [`SCH_SYNC_W-1:0]    sync1;
      logic [`SCH_SYNC_W-1:0]    sync2;
      logic [`SCH_SYNC_W-1:0]    sync3;
      logic                      rsp_valid;
      sch_pkg::sch_rsp_t         rsp_kind;
      logic                      rsp_mode;
      logic [`SCH_TIME_W-1:0]    rsp_time;
      logic signed [LOAD_W-1:0]  rsp_limit;
      logic                      auto_mode;
      logic [`SCH_TIME_W-1:0]    idle_time;
      logic signed [LOAD_W-1:0]  zlimit;
      logic                      remind_on;
      logic                      icon;
      sch_pkg::sch_pwr_t         pwr;
   } sch_top_state_t;

   sch_top_state_t st_ff;
   sch_top_state_t nxt_st;
   sch_idle_if     idle ();
   logic           zt_press;
   logic           activity;
   logic           down_cmd;
   logic           down_req;

   // a negative erase value would be a limit that no set command can write
   generate
      if (ZLIMIT_RST[LOAD_W-1]) begin : g_bad_rst
         $error("ZLIMIT_RST must not be negative");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // outcome of a set command; parameter check outranks busy
   function automatic sch_pkg::sch_rsp_t set_outcome(input logic bad, input logic busy);
      if (bad) begin
         set_outcome = sch_pkg::rsp_param_error;
      end else if (busy) begin
         set_outcome = sch_pkg::rsp_busy;
      end else begin
         set_outcome = sch_pkg::rsp_ack;
      end
   endfunction

   // pins: bit 0 battery, bit 1 zero/tare key, bit 2 other keys; edges use stage 2 vs 3
   assign zt_press = st_ff.sync2[1] & ~st_ff.sync3[1];
   assign activity = i_cmd_valid | zt_press | (st_ff.sync2[2] & ~st_ff.sync3[2]);

   // timer only steers power while the mode and a non-zero time allow it
   assign idle.restart = activity;
   assign idle.enable  = st_ff.auto_mode;
   assign idle.limit   = st_ff.idle_time;
   assign down_cmd     = i_cmd_valid && i_cmd_code == sch_pkg::power_down_cmd && !i_exec_busy;
   assign down_req     = down_cmd ||
                         (idle.expire && st_ff.auto_mode && st_ff.idle_time != '0);

   ////////////////////////////////////////////////////////////////////////
   // command decode, setting store, power state and reminder icon
   always_comb begin
      nxt_st           = st_ff;
      nxt_st.sync1     = {i_key_any, i_key_zt, i_on_battery};
      nxt_st.sync2     = st_ff.sync1;
      nxt_st.sync3     = st_ff.sync2;
      nxt_st.rsp_valid = 1'b0;
      if (i_nv_erase) begin
         nxt_st.auto_mode = `SCH_RST_AUTO;
         nxt_st.idle_time = `SCH_RST_TIME;
         nxt_st.remind_on = `SCH_RST_REMIND;
         nxt_st.zlimit    = ZLIMIT_RST;
      end
      // no reply ready: the host holds off until each reply is seen
      if (i_cmd_valid) begin
         nxt_st.rsp_valid = 1'b1;
         nxt_st.rsp_mode  = 1'b0;
         nxt_st.rsp_time  = '0;
         nxt_st.rsp_limit = '0;
         case (i_cmd_code)
            sch_pkg::auto_off_setting_cmd: begin
               if (i_cmd_query) begin
                  nxt_st.rsp_kind = sch_pkg::rsp_query_data;
                  nxt_st.rsp_mode = st_ff.auto_mode;
                  nxt_st.rsp_time = st_ff.idle_time;
               end else begin
                  nxt_st.rsp_kind = set_outcome(i_cmd_mode > `SCH_MODE_MAX ||
                     i_cmd_time > `SCH_CMD_TIME_W'(`SCH_TIME_MAX), i_exec_busy);
                  if (nxt_st.rsp_kind == sch_pkg::rsp_ack) begin
                     nxt_st.auto_mode = i_cmd_mode[0];
                     nxt_st.idle_time = i_cmd_time[`SCH_TIME_W-1:0];
                  end
               end
            end
            sch_pkg::zero_range_limit_cmd: begin
               if (i_cmd_query) begin
                  nxt_st.rsp_kind  = sch_pkg::rsp_query_data;
                  nxt_st.rsp_limit = st_ff.zlimit;
               end else begin
                  nxt_st.rsp_kind = set_outcome(i_cmd_limit < 0, i_exec_busy);
                  if (nxt_st.rsp_kind == sch_pkg::rsp_ack) begin
                     nxt_st.zlimit = i_cmd_limit;
                  end
               end
            end
            sch_pkg::service_reminder_cmd: begin
               if (i_cmd_query) begin
                  nxt_st.rsp_kind = sch_pkg::rsp_query_data;
                  nxt_st.rsp_mode = st_ff.remind_on;
               end else begin
                  nxt_st.rsp_kind = set_outcome(i_cmd_mode > `SCH_MODE_MAX, i_exec_busy);
                  if (nxt_st.rsp_kind == sch_pkg::rsp_ack) begin
                     nxt_st.remind_on = i_cmd_mode[0];
                  end
               end
            end
            sch_pkg::power_down_cmd: begin
               nxt_st.rsp_kind = set_outcome(1'b0, i_exec_busy);
            end
            default: begin
               nxt_st.rsp_kind = sch_pkg::rsp_param_error;
            end
         endcase
      end
      // supply decides the depth of power-down; no wake path is modelled
      case (st_ff.pwr)
         sch_pkg::pwr_run: begin
            if (down_req) begin
               nxt_st.pwr = st_ff.sync2[0] ? sch_pkg::pwr_off : sch_pkg::pwr_standby;
            end
         end
         sch_pkg::pwr_standby: nxt_st.pwr = sch_pkg::pwr_standby;
         sch_pkg::pwr_off:     nxt_st.pwr = sch_pkg::pwr_off;
         default:              nxt_st.pwr = sch_pkg::pwr_run;
      endcase
      nxt_st.icon = st_ff.remind_on & (i_service_due | i_hours_due);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_ff           <= '0;
         st_ff.auto_mode <= `SCH_RST_AUTO;
         st_ff.idle_time <= `SCH_RST_TIME;
         st_ff.remind_on <= `SCH_RST_REMIND;
         st_ff.zlimit    <= ZLIMIT_RST;
         st_ff.pwr       <= sch_pkg::pwr_run;
      end else if (i_clk_en) begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // helpers
   sch_idle_timer #(.CYC_PER_SEC(CYC_PER_SEC)) u_timer (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_clk_en   (i_clk_en),
      .idle       (idle.timer)
   );

   sch_zero_tare #(.LOAD_W(LOAD_W)) u_zt (
      .i_core_clk     (i_core_clk),
      .i_sys_rst      (i_sys_rst),
      .i_clk_en       (i_clk_en),
      .i_press        (zt_press),
      .i_zero_capture (i_zero_capture),
      .i_load         (i_load),
      .i_limit        (st_ff.zlimit),
      .o_do_zero      (o_do_zero),
      .o_do_tare      (o_do_tare)
   );

   assign o_rsp_valid     = st_ff.rsp_valid;
   assign o_rsp_kind      = st_ff.rsp_kind;
   assign o_rsp_mode      = st_ff.rsp_mode;
   assign o_rsp_time      = st_ff.rsp_time;
   assign o_rsp_limit     = st_ff.rsp_limit;
   assign o_standby       = st_ff.pwr == sch_pkg::pwr_standby;
   assign o_power_off     = st_ff.pwr == sch_pkg::pwr_off;
   assign o_reminder_icon = st_ff.icon;

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_query_auto;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_clk_en && i_cmd_valid && i_cmd_query && i_cmd_code == sch_pkg::auto_off_setting_cmd)
      |=> o_rsp_valid && o_rsp_kind == sch_pkg::rsp_query_data &&
          o_rsp_mode == $past(st_ff.auto_mode) && o_rsp_time == $past(st_ff.idle_time);
   endproperty
   a_query_auto: assert property (p_query_auto) else $error("auto-off query reply wrong");

   property p_bad_time;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_clk_en && i_cmd_valid && !i_cmd_query && !i_nv_erase &&
       i_cmd_code == sch_pkg::auto_off_setting_cmd &&
       i_cmd_time > `SCH_CMD_TIME_W'(`SCH_TIME_MAX))
      |=> o_rsp_kind == sch_pkg::rsp_param_error && $stable(st_ff.idle_time);
   endproperty
   a_bad_time: assert property (p_bad_time) else $error("over-range time taken");

   property p_busy_set;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_clk_en && i_cmd_valid && !i_cmd_query && i_exec_busy && !i_nv_erase &&
       i_cmd_code == sch_pkg::zero_range_limit_cmd && i_cmd_limit >= 0)
      |=> o_rsp_kind == sch_pkg::rsp_busy && $stable(st_ff.zlimit);
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy set not refused");

   property p_no_auto_off;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_clk_en && st_ff.pwr == sch_pkg::pwr_run && !down_cmd &&
       (!st_ff.auto_mode || st_ff.idle_time == '0)) |=> st_ff.pwr == sch_pkg::pwr_run;
   endproperty
   a_no_auto_off: assert property (p_no_auto_off) else $error("powered down while disabled");

   property p_idle_down;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_clk_en && st_ff.pwr == sch_pkg::pwr_run && idle.expire && st_ff.auto_mode &&
       st_ff.idle_time != '0) |=> st_ff.pwr != sch_pkg::pwr_run;
   endproperty
   a_idle_down: assert property (p_idle_down) else $error("idle expiry ignored");

   property p_cable_standby;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_clk_en && st_ff.pwr == sch_pkg::pwr_run && down_cmd && !st_ff.sync2[0])
      |=> o_standby && !o_power_off;
   endproperty
   a_cable_standby: assert property (p_cable_standby) else $error("cable power not standby");

   property p_batt_off;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_clk_en && st_ff.pwr == sch_pkg::pwr_run && down_cmd && st_ff.sync2[0])
      |=> o_power_off && !o_standby;
   endproperty
   a_batt_off: assert property (p_batt_off) else $error("battery power not off");

   property p_icon_on;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_clk_en && st_ff.remind_on && (i_service_due || i_hours_due)) |=> o_reminder_icon;
   endproperty
   a_icon_on: assert property (p_icon_on) else $error("reminder icon missing");

   property p_icon_off;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_clk_en && !st_ff.remind_on) |=> !o_reminder_icon;
   endproperty
   a_icon_off: assert property (p_icon_off) else $error("reminder icon while off");

   property p_erase;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_clk_en && i_nv_erase && !i_cmd_valid) |=> st_ff.idle_time == '0 && !st_ff.auto_mode;
   endproperty
   a_erase: assert property (p_erase) else $error("erase left idle time");
endmodule // sch_settings_top

// ==== testbench/sch_host_model.sv ====
// Purpose: host end of the command link
// Assumes: one reply follows each command within a few cycles
// Notes:   mode field is scrambled once the strobe drops
`timescale 1ns/100ps
module sch_host_model (
   input  wire logic         i_core_clk,                         // system clock
   input  wire logic         i_rsp_valid,                        // reply pulse
   output logic              o_cmd_valid = 1'h0,                 // command strobe
   output sch_pkg::sch_cmd_t o_cmd_code = sch_pkg::power_down_cmd, // command code
   output logic              o_cmd_query = 1'h0,                 // query form
   output logic [1:0]        o_cmd_mode = 2'h0,                  // mode field
   output logic [19:0]       o_cmd_time = 20'h00000,             // seconds field
   output logic [23:0]       o_cmd_limit = 24'h000000            // limit field
);
   ////////////////////////////////////////
   // one command, then wait for its reply so nothing overlaps
   task automatic send(input sch_pkg::sch_cmd_t c, input logic q, input logic [1:0] m,
                       input logic [19:0] t, input logic [23:0] l);
      @(posedge i_core_clk);
      o_cmd_valid <= 1'h1;
      o_cmd_code  <= c;
      o_cmd_query <= q;
      o_cmd_mode  <= m;
      o_cmd_time  <= t;
      o_cmd_limit <= l;
      @(posedge i_core_clk);
      o_cmd_valid <= 1'h0;
      o_cmd_mode  <= ~m;
      #1;
      for (int i = 0; i < 4 && i_rsp_valid !== 1'h1; i++) @(posedge i_core_clk);
   endtask
endmodule // sch_host_model

// ==== testbench/scale_settings_command_handler_test.sv ====
// Purpose: self-checking bench for the settings command handler
// Assumes: one second shortened to 4 clocks
// Notes:   key and idle paths carry a few cycles of synchroniser delay
`timescale 1ns/100ps
module scale_settings_command_handler_test;
   localparam sch_pkg::sch_cmd_t AO = sch_pkg::auto_off_setting_cmd;
   localparam sch_pkg::sch_rsp_t QD = sch_pkg::rsp_query_data;
   localparam sch_pkg::sch_rsp_t PE = sch_pkg::rsp_param_error;
   localparam sch_pkg::sch_rsp_t AK = sch_pkg::rsp_ack;
   logic i_core_clk = 1'h0, i_sys_rst = 1'h1, i_clk_en = 1'h1, i_exec_busy = 1'h0;
   logic i_nv_erase = 1'h0, i_on_battery = 1'h0, i_key_zt = 1'h0, i_key_any = 1'h0;
   logic i_zero_capture = 1'h0, i_service_due = 1'h0, i_hours_due = 1'h0;
   logic signed [23:0] i_load = 24'h000007, i_cmd_limit, o_rsp_limit;
   logic i_cmd_valid, i_cmd_query, o_rsp_valid, o_rsp_mode, o_standby, o_power_off;
   logic o_do_zero, o_do_tare, o_reminder_icon;
   logic [1:0] i_cmd_mode;
   logic [19:0] i_cmd_time;
   logic [15:0] o_rsp_time;
   sch_pkg::sch_cmd_t i_cmd_code;
   sch_pkg::sch_rsp_t o_rsp_kind;
   int errors = 0, num_checks = 0, cyc = 0;
   sch_host_model u_host (.i_core_clk, .i_rsp_valid(o_rsp_valid), .o_cmd_valid(i_cmd_valid),
      .o_cmd_code(i_cmd_code), .o_cmd_query(i_cmd_query), .o_cmd_mode(i_cmd_mode),
      .o_cmd_time(i_cmd_time), .o_cmd_limit(i_cmd_limit));
   sch_settings_top #(.CYC_PER_SEC(4)) u_dut (.i_core_clk, .i_sys_rst, .i_clk_en, .i_cmd_valid,
      .i_cmd_code, .i_cmd_query, .i_cmd_mode, .i_cmd_time, .i_cmd_limit, .i_exec_busy,
      .i_nv_erase, .i_on_battery, .i_key_zt, .i_key_any, .i_load, .i_zero_capture,
      .i_service_due, .i_hours_due, .o_rsp_valid, .o_rsp_kind, .o_rsp_mode, .o_rsp_time,
      .o_rsp_limit, .o_standby, .o_power_off, .o_do_zero, .o_do_tare, .o_reminder_icon);
   ////////////////////////////////////////
   // clock, and a cycle ceiling well above the whole run
   always #20 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         end_sim();
      end
   end
   ////////////////////////////////////////
   // compare, verdict, reset and command helpers
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp)
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      if (got !== exp)
         errors++;
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic do_reset;
      i_sys_rst <= 1'h1;
      repeat (5) @(posedge i_core_clk);
      i_sys_rst <= 1'h0;
   endtask
   // reply pulse and its fields are judged together in the reply cycle
   task automatic cmd(input sch_pkg::sch_cmd_t c, input logic q, input logic [1:0] m,
      input logic [19:0] t, input logic [23:0] l, input sch_pkg::sch_rsp_t k,
      input logic em, input logic [15:0] et);
      u_host.send(c, q, m, t, l);
      chk({o_rsp_valid, o_rsp_kind, o_rsp_mode, o_rsp_time}, {1'h1, k, em, et});
   endtask
   // key press at a given load; exactly one of zero or tare must pulse
   task automatic press(input logic [23:0] ld, input logic zero);
      logic z = 1'h0;
      logic t = 1'h0;
      @(posedge i_core_clk);
      i_load   <= ld;
      i_key_zt <= 1'h1;
      repeat (8) begin
         @(posedge i_core_clk);
         #1;
         z = z | o_do_zero;
         t = t | o_do_tare;
      end
      i_key_zt <= 1'h0;
      chk({z, t}, {zero, ~zero});
   endtask
   ////////////////////////////////////////
   // scenarios
   task automatic t_store;
      cmd(AO, 1, 0, 0, 0, QD, 0, 0);
      cmd(AO, 0, 1, 43200, 0, AK, 0, 0);
      cmd(AO, 0, 1, 43201, 0, PE, 0, 0);
      cmd(AO, 0, 2, 5, 0, PE, 0, 0);
      @(posedge i_core_clk) i_exec_busy <= 1'h1;
      cmd(AO, 0, 0, 9, 0, sch_pkg::rsp_busy, 0, 0);
      @(posedge i_core_clk) i_exec_busy <= 1'h0;
      cmd(AO, 1, 0, 0, 0, QD, 1, 16'ha8c0);
      @(posedge i_core_clk) i_clk_en <= 1'h0;
      @(posedge i_core_clk) i_nv_erase <= 1'h1;
      @(posedge i_core_clk) {i_clk_en, i_nv_erase} <= 2'h2;
      cmd(AO, 1, 0, 0, 0, QD, 1, 16'ha8c0);
      @(posedge i_core_clk) i_nv_erase <= 1'h1;
      @(posedge i_core_clk) i_nv_erase <= 1'h0;
      cmd(AO, 1, 0, 0, 0, QD, 0, 0);
   endtask
   task automatic t_remind;
      @(posedge i_core_clk) i_hours_due <= 1'h1;
      cmd(sch_pkg::service_reminder_cmd, 0, 1, 0, 0, AK, 0, 0);
      cmd(sch_pkg::service_reminder_cmd, 1, 0, 0, 0, QD, 1, 0);
      chk(o_reminder_icon, 1);
      @(posedge i_core_clk) i_service_due <= 1'h1;
      cmd(sch_pkg::service_reminder_cmd, 0, 0, 0, 0, AK, 0, 0);
      repeat (2) @(posedge i_core_clk);
      chk(o_reminder_icon, 0);
   endtask
   task automatic t_zero;
      @(posedge i_core_clk) i_zero_capture <= 1'h1;
      @(posedge i_core_clk) i_zero_capture <= 1'h0;
      cmd(sch_pkg::zero_range_limit_cmd, 0, 0, 0, 100, AK, 0, 0);
      @(posedge i_core_clk) i_exec_busy <= 1'h1;
      cmd(sch_pkg::zero_range_limit_cmd, 0, 0, 0, 50, sch_pkg::rsp_busy, 0, 0);
      @(posedge i_core_clk) i_exec_busy <= 1'h0;
      cmd(sch_pkg::zero_range_limit_cmd, 1, 0, 0, 0, QD, 0, 0);
      chk(o_rsp_limit, 100);
      cmd(sch_pkg::zero_range_limit_cmd, 0, 0, 0, -1, PE, 0, 0);
      press(107, 1);
      press(108, 0);
   endtask
   task automatic t_idle;
      cmd(AO, 0, 0, 2, 0, AK, 0, 0);
      repeat (20) @(posedge i_core_clk);
      cmd(AO, 1, 0, 0, 0, QD, 0, 2);
      chk(o_standby, 0);
      cmd(AO, 0, 1, 0, 0, AK, 0, 0);
      repeat (20) @(posedge i_core_clk);
      chk(o_standby, 0);
      cmd(AO, 0, 1, 2, 0, AK, 0, 0);
      repeat (5) @(posedge i_core_clk);
      i_key_any <= 1'h1;
      repeat (8) @(posedge i_core_clk);
      i_key_any <= 1'h0;
      chk(o_standby, 0);
      repeat (8) @(posedge i_core_clk);
      chk({o_standby, o_power_off}, 2'h2);
   endtask
   // cable pass, then battery pass; the supply pin needs its synchroniser time
   task automatic t_battery;
      for (int b = 0; b < 2; b++) begin
         i_on_battery <= 1'(b);
         do_reset();
         repeat (3) @(posedge i_core_clk);
         cmd(sch_pkg::power_down_cmd, 0, 0, 0, 0, AK, 0, 0);
         repeat (2) @(posedge i_core_clk);
         chk({o_standby, o_power_off}, b ? 2'h1 : 2'h2);
      end
   endtask
   initial begin
      do_reset();
      t_store();
      t_remind();
      t_zero();
      t_idle();
      t_battery();
      end_sim();
   end
endmodule // scale_settings_command_handler_test
